//--- hw/toie_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "toie_map.svh"
module toie_alu
  import toie_pkg::*;
(
  // Operation select.
  input wire logic [3:0] opc_in,
  input wire logic byte_in,
  // Operands.
  input wire logic [15:0] src_in,
  input wire logic [15:0] dst_in,
  input wire logic [15:0] sr_in,
  // Results.
  output logic [15:0] res_out,
  output logic [15:0] sr_out,
  output logic write_out
);
  logic [16:0] sum;
  logic [15:0] r;
  logic [3:0] dig;
  logic dc;
  logic cy;
  logic msb;
  logic smsb;
  logic dmsb;
  logic arith;
  logic logic_op;
  logic [15:0] b;
  logic cin;
  logic [4:0] t;
  always_comb begin
    sum = 17'h00000;
    r = dst_in;
    dig = 4'h0;
    dc = 1'b0;
    cy = 1'b0;
    arith = 1'b0;
    logic_op = 1'b0;
    b = src_in;
    cin = 1'b0;
    t = 5'h00;
    write_out = 1'b1;
    sr_out = sr_in;
    case (opc_in)
      toie_copy_op: r = src_in; // RULE10
      toie_add_op, toie_add_carry_op,
      toie_sub_op, toie_subtract_carry_op, toie_compare_op: begin
        arith = 1'b1;
        if (opc_in == toie_sub_op || opc_in == toie_compare_op ||
            opc_in == toie_subtract_carry_op) begin
          b = ~src_in; // RULE13 RULE14
        end
        if (opc_in == toie_add_op) begin
          cin = 1'b0; // RULE11
        end else if (opc_in == toie_sub_op || opc_in == toie_compare_op) begin
          cin = 1'b1; // RULE13
        end else begin
          cin = sr_in[`TOIE_SR_C]; // RULE12 RULE14
        end
        if (byte_in) begin
          sum = {8'h00, {1'b0, dst_in[7:0]} + {1'b0, b[7:0]} + {8'h00, cin}};
          cy = sum[8];
        end else begin
          sum = {1'b0, dst_in} + {1'b0, b} + {16'h0000, cin};
          cy = sum[16];
        end
        r = sum[15:0];
        write_out = (opc_in != toie_compare_op); // RULE15
      end
      toie_decimal_add_op: begin
        dc = sr_in[`TOIE_SR_C];
        for (int i = 0; i < 4; i++) begin
          t = {1'b0, dst_in[i*4 +: 4]} + {1'b0, src_in[i*4 +: 4]} +
              {4'h0, dc}; // RULE24
          if (t > 5'h09) begin
            t = t + 5'h06;
            dc = 1'b1;
          end else begin
            dc = 1'b0;
          end
          r[i*4 +: 4] = t[3:0];
          if (byte_in && i == 1) begin
            cy = dc;
          end
        end
        if (!byte_in) begin
          cy = dc; // RULE16
        end
        arith = 1'b1;
      end
      toie_bit_test_op, toie_and_op: begin
        r = src_in & dst_in; // RULE17
        logic_op = 1'b1;
        write_out = (opc_in == toie_and_op); // RULE18
      end
      toie_bit_clear_op: r = ~src_in & dst_in; // RULE19
      toie_bit_set_op: r = src_in | dst_in; // RULE20
      toie_xor_op: begin
        r = src_in ^ dst_in; // RULE21
        logic_op = 1'b1;
      end
      default: write_out = 1'b0;
    endcase
    if (byte_in) begin
      r = {8'h00, r[7:0]}; // RULE23
    end
    msb = byte_in ? r[7] : r[15];
    smsb = byte_in ? b[7] : b[15];
    dmsb = byte_in ? dst_in[7] : dst_in[15];
    if (arith) begin
      sr_out[`TOIE_SR_C] = cy;
      sr_out[`TOIE_SR_N] = msb;
      sr_out[`TOIE_SR_Z] = (r == 16'h0000);
      sr_out[`TOIE_SR_V] = (opc_in == toie_decimal_add_op) ? 1'b0 :
                           (smsb == dmsb) && (msb != dmsb);
    end else if (logic_op) begin
      sr_out[`TOIE_SR_C] = (r != 16'h0000);
      sr_out[`TOIE_SR_N] = msb;
      sr_out[`TOIE_SR_Z] = (r == 16'h0000);
      sr_out[`TOIE_SR_V] = (opc_in == toie_xor_op) ?
                           (byte_in ? (src_in[7] & dst_in[7]) :
                           (src_in[15] & dst_in[15])) : 1'b0; // RULE17
    end
    res_out = r;
  end
endmodule
`default_nettype wire

//--- hw/toie_core.sv
// Operation
// RULE1 - Twenty-seven core operations, each unique opcode; the core executes only the twelve double-operand ones
// RULE2 - Dispatch double, single and jump formats
// RULE3 - Size bit zero word, one byte
// RULE4 - Source and destination mode/register fields
// RULE5 - Immediate constant read through advancing PC
// RULE6 - Immediate instruction spans two or three words
// RULE7 - Generator constants consume no extension word
// RULE8 - Immediate mode only as source
// RULE9 - Writes issued to any destination address
// RULE10 - Copy leaves all flags unchanged
// RULE11 - Add updates all four flags
// RULE12 - Add with carry uses carry flag
// RULE13 - Subtract is dst plus inverted src plus one
// RULE14 - Subtract with carry uses carry flag
// RULE15 - Compare subtracts but does not write
// RULE16 - Decimal add stores BCD sum, flags
// RULE17 - AND clears overflow, sets other flags
// RULE18 - Bit test flags like AND, no write
// RULE19 - Bit clear keeps flags
// RULE20 - Bit set keeps flags
// RULE21 - Exclusive OR updates all four flags
// RULE22 - Autoincrement after fetch by one or two
// RULE23 - Byte flags from bit seven, upper cleared
// RULE24 - Decimal add corrects digits with carry
`timescale 1ns/1ps
`default_nettype none
`include "toie_map.svh"
module toie_core
  import toie_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Memory bus.
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic mem_byte_out,
  input wire logic [15:0] mem_rdata_in,
  input wire logic mem_ready_in,
  // Status.
  output logic [15:0] pc_out,
  output logic [15:0] sr_out,
  output logic [15:0] insn_out,
  output logic [1:0] fmt_out,
  output logic other_fmt_out,
  output logic illegal_out,
  output logic busy_out
);
  typedef enum logic [2:0] {
    toie_st_fetch,
    toie_st_src,
    toie_st_dext,
    toie_st_dread,
    toie_st_exec,
    toie_st_write
  } toie_state_t;

  typedef struct packed {
    toie_state_t st;
    logic [15:0] pc;
    logic [15:0][15:0] regs;
    logic [15:0] ir;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] daddr;
    logic [15:0] waddr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic wbyte;
    logic other;
    logic illegal;
    logic [1:0] fmt;
  } toie_state_s_t;

  toie_state_s_t s;
  toie_state_s_t next_s;
  logic [15:0] alu_res;
  logic [15:0] alu_sr;
  logic alu_wr;

  // ******************************
  // Decode helpers
  // ******************************
  function automatic logic [1:0] fmt_of(input logic [15:0] w);
    if (w[15:12] >= 4'h4) begin
      return toie_fmt_double; // RULE2
    end else if (w[15:13] == 3'b001) begin
      return toie_fmt_jump;
    end else if (w[15:10] == 6'b000100) begin
      return toie_fmt_single;
    end
    return toie_fmt_bad;
  endfunction

  // Returns 1 with the value when the generator supplies the constant.
  function automatic logic [16:0] const_gen(input logic [3:0] r,
                                            input logic [1:0] m);
    if (r == `TOIE_REG_CG) begin
      case (m) // RULE7
        2'b00: return {1'b1, 16'h0000};
        2'b01: return {1'b1, 16'h0001};
        2'b10: return {1'b1, 16'h0002};
        default: return {1'b1, 16'hffff};
      endcase
    end else if (r == `TOIE_REG_SR && m[1]) begin
      return {1'b1, m[0] ? 16'h0008 : 16'h0004};
    end
    return {1'b0, 16'h0000};
  endfunction

  function automatic logic [15:0] rd_reg(input toie_state_s_t x,
                                         input logic [3:0] r);
    return (r == `TOIE_REG_PC) ? x.pc : x.regs[r];
  endfunction

  // ******************************
  // Operand fields
  // ******************************
  logic [3:0] sreg;
  logic [3:0] dreg;
  logic [1:0] src_mode_field;
  logic dst_mode;
  logic byte_op;
  logic [16:0] cg;
  assign sreg = s.ir[`TOIE_SREG_HI:`TOIE_SREG_LO]; // RULE4
  assign dreg = s.ir[`TOIE_DREG_HI:`TOIE_DREG_LO];
  assign src_mode_field = s.ir[`TOIE_AS_HI:`TOIE_AS_LO];
  assign dst_mode = s.ir[`TOIE_AD_BIT];
  assign byte_op = s.ir[`TOIE_BW_BIT]; // RULE3
  assign cg = const_gen(sreg, src_mode_field);

  toie_alu u_alu (
    .opc_in(s.ir[`TOIE_OPC_HI:`TOIE_OPC_LO]),
    .byte_in(byte_op),
    .src_in(s.src),
    .dst_in(s.dst),
    .sr_in(s.regs[`TOIE_REG_SR]),
    .res_out(alu_res),
    .sr_out(alu_sr),
    .write_out(alu_wr)
  );

  // ******************************
  // Sequencer
  // ******************************
  always_comb begin
    next_s = s;
    next_s.rd = 1'b0;
    next_s.wr = 1'b0;
    case (s.st)
      toie_st_fetch: begin
        next_s.rd = 1'b1;
        if (s.rd && mem_ready_in) begin
          next_s.rd = 1'b0;
          next_s.ir = mem_rdata_in;
          next_s.pc = s.pc + `TOIE_WORD_STEP;
          next_s.fmt = fmt_of(mem_rdata_in);
          next_s.other = (fmt_of(mem_rdata_in) != toie_fmt_double);
          next_s.illegal = (fmt_of(mem_rdata_in) == toie_fmt_bad);
          if (fmt_of(mem_rdata_in) == toie_fmt_double) begin
            next_s.st = toie_st_src; // RULE1
          end
        end
      end
      toie_st_src: begin
        if (cg[16]) begin
          next_s.src = cg[15:0]; // RULE7
          next_s.st = toie_st_dext;
        end else if (src_mode_field == 2'b00) begin
          next_s.src = rd_reg(s, sreg);
          next_s.st = toie_st_dext;
        end else begin
          // Immediate is @PC+; the PC step happens after the fetch.
          next_s.rd = 1'b1;
          if (s.rd && mem_ready_in) begin
            next_s.rd = 1'b0;
            next_s.src = mem_rdata_in; // RULE5
            next_s.st = toie_st_dext;
            if (src_mode_field[1]) begin
              if (sreg == `TOIE_REG_PC) begin
                next_s.pc = s.pc + `TOIE_WORD_STEP; // RULE5 RULE6
              end else if (src_mode_field[0]) begin
                next_s.regs[sreg] = s.regs[sreg] + (byte_op ?
                  `TOIE_BYTE_STEP : `TOIE_WORD_STEP); // RULE22
              end
            end
          end
        end
      end
      toie_st_dext: begin
        // Destination mode is one bit, so immediate cannot arise here.
        if (!dst_mode) begin
          next_s.dst = rd_reg(s, dreg); // RULE8
          next_s.st = toie_st_exec;
        end else begin
          next_s.rd = 1'b1;
          if (s.rd && mem_ready_in) begin
            next_s.rd = 1'b0;
            next_s.pc = s.pc + `TOIE_WORD_STEP; // RULE6
            next_s.daddr = mem_rdata_in + ((dreg == `TOIE_REG_SR) ?
              16'h0000 : rd_reg(s, dreg));
            next_s.st = toie_st_dread;
          end
        end
      end
      toie_st_dread: begin
        next_s.rd = 1'b1;
        if (s.rd && mem_ready_in) begin
          next_s.rd = 1'b0;
          next_s.dst = byte_op ? (s.daddr[0] ? {8'h00, mem_rdata_in[15:8]} :
            {8'h00, mem_rdata_in[7:0]}) : mem_rdata_in;
          next_s.st = toie_st_exec;
        end
      end
      toie_st_exec: begin
        next_s.regs[`TOIE_REG_SR] = alu_sr;
        next_s.st = toie_st_fetch;
        if (alu_wr) begin
          if (dst_mode) begin
            next_s.waddr = s.daddr;
            next_s.wdata = (byte_op && s.daddr[0]) ?
              {alu_res[7:0], 8'h00} : alu_res;
            next_s.wbyte = byte_op;
            next_s.wr = 1'b1;
            next_s.st = toie_st_write; // RULE9
          end else if (dreg == `TOIE_REG_PC) begin
            next_s.pc = alu_res;
          end else if (dreg != `TOIE_REG_CG) begin
            next_s.regs[dreg] = alu_res; // RULE23
          end
        end
      end
      toie_st_write: begin
        // No fault path: a read-only target simply ignores the data.
        next_s.wr = 1'b1;
        if (s.wr && mem_ready_in) begin
          next_s.wr = 1'b0;
          next_s.st = toie_st_fetch; // RULE9
        end
      end
      default: next_s.st = toie_st_fetch;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.pc <= `TOIE_PC_RESET;
      s.st <= toie_st_fetch;
    end else begin
      s <= next_s;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  always_comb begin
    case (s.st)
      // Indirect and immediate sources read through their register.
      toie_st_src: mem_addr_out = rd_reg(s, sreg); // RULE5
      toie_st_dread: mem_addr_out = s.daddr;
      toie_st_write: mem_addr_out = s.waddr; // RULE9
      default: mem_addr_out = s.pc;
    endcase
  end
  assign mem_wdata_out = s.wdata;
  assign mem_rd_out = s.rd;
  assign mem_wr_out = s.wr;
  assign mem_byte_out = s.wbyte & s.wr;
  assign pc_out = s.pc;
  assign sr_out = s.regs[`TOIE_REG_SR];
  assign insn_out = s.ir;
  assign fmt_out = s.fmt;
  assign other_fmt_out = s.other;
  assign illegal_out = s.illegal;
  assign busy_out = (s.st != toie_st_fetch);
endmodule
`default_nettype wire

//--- hw/toie_map.svh
`ifndef TOIE_MAP_SVH
`define TOIE_MAP_SVH
// Instruction field positions.
`define TOIE_OPC_HI 15
`define TOIE_OPC_LO 12
`define TOIE_SREG_HI 11
`define TOIE_SREG_LO 8
`define TOIE_AD_BIT 7
`define TOIE_BW_BIT 6
`define TOIE_AS_HI 5
`define TOIE_AS_LO 4
`define TOIE_DREG_HI 3
`define TOIE_DREG_LO 0
// Special registers.
`define TOIE_REG_PC 4'h0
`define TOIE_REG_SR 4'h2
`define TOIE_REG_CG 4'h3
// Status register bit positions.
`define TOIE_SR_C 0
`define TOIE_SR_Z 1
`define TOIE_SR_N 2
`define TOIE_SR_V 8
// Reset value and address steps.
`define TOIE_PC_RESET 16'h0000
`define TOIE_WORD_STEP 16'h0002
`define TOIE_BYTE_STEP 16'h0001
`endif

//--- hw/toie_pkg.sv
package toie_pkg;
  typedef enum logic [3:0] {
    toie_copy_op = 4'h4,
    toie_add_op = 4'h5,
    toie_add_carry_op = 4'h6,
    toie_subtract_carry_op = 4'h7,
    toie_sub_op = 4'h8,
    toie_compare_op = 4'h9,
    toie_decimal_add_op = 4'ha,
    toie_bit_test_op = 4'hb,
    toie_bit_clear_op = 4'hc,
    toie_bit_set_op = 4'hd,
    toie_xor_op = 4'he,
    toie_and_op = 4'hf
  } toie_op_t;
  typedef enum logic [1:0] {
    toie_fmt_double,
    toie_fmt_single,
    toie_fmt_jump,
    toie_fmt_bad
  } toie_fmt_t;
endpackage

//--- test/toie_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module toie_core_props
  import toie_pkg::*;
(
  // Clock, reset and bus.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic mem_byte_out,
  input wire logic [15:0] mem_rdata_in,
  input wire logic mem_ready_in,
  // Core state.
  input wire logic [15:0] sr_out,
  input wire logic [15:0] insn_out,
  input wire logic busy_out
);
  logic [15:0] fetch_addr;
  logic [3:0] opc;
  assign opc = insn_out[15:12];
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_addr <= 16'h0000;
    end else if (!busy_out && mem_rd_out && mem_ready_in) begin
      fetch_addr <= mem_addr_out;
    end
  end
  default clocking dc @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  rd_wr_excl_a: assert property (
    !(mem_rd_out && mem_wr_out)) else $error("read and write at once");
  rd_hold_a: assert property (
    mem_rd_out && !mem_ready_in |=> mem_rd_out && $stable(mem_addr_out))
    else $error("read request dropped early");
  wr_hold_a: assert property (
    mem_wr_out && !mem_ready_in |=> mem_wr_out && $stable(mem_wdata_out))
    else $error("write request dropped early");
  // The constant word must be read right after the opcode, at PC plus 2.
  imm_pc_a: assert property (
    !busy_out && mem_rd_out && mem_ready_in && mem_rdata_in[15:14] != 2'h0
    && mem_rdata_in[11:8] == 4'h0 && mem_rdata_in[5:4] == 2'h3
    |=> ##[0:3] mem_rd_out && mem_addr_out == fetch_addr + 16'h0002)
    else $error("immediate not read through pc");
  keep_flags_a: assert property (
    busy_out && opc inside {4'h4, 4'hc, 4'hd} |=> $stable(sr_out))
    else $error("flags changed by flag-neutral op");
  no_write_a: assert property (
    busy_out && opc inside {4'h9, 4'hb} |-> !mem_wr_out)
    else $error("compare or test wrote memory");
  v_clear_a: assert property (
    $fell(busy_out) && opc inside {4'hb, 4'hf} |-> !sr_out[8])
    else $error("overflow not cleared");
  byte_lane_a: assert property (
    mem_wr_out && opc[3:2] != 2'h0 |-> mem_byte_out == insn_out[6])
    else $error("write size differs from size bit");
endmodule
bind toie_core toie_core_props u_props (.*);
`default_nettype wire

//--- test/toie_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module toie_core_tb
  import toie_pkg::*;
;
  logic sys_clk_in;
  logic rst_in;
  logic [15:0] addr, wdata, rdata, pc, sr, insn, wr_count, pc_exp, sr_exp;
  logic rd, wr, byte_sel, ready, busy, other_fmt, stall;
  logic [1:0] fmt;
  int n_fail;
  int checks;
  int i;
  toie_core u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_rd_out(rd),
    .mem_wr_out(wr), .mem_byte_out(byte_sel), .mem_rdata_in(rdata),
    .mem_ready_in(ready), .pc_out(pc), .sr_out(sr), .insn_out(insn),
    .fmt_out(fmt), .other_fmt_out(other_fmt), .illegal_out(),
    .busy_out(busy));
  toie_mem_model u_mem (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .rd_in(rd), .wr_in(wr),
    .byte_in(byte_sel), .stall_in(stall), .rdata_out(rdata),
    .ready_out(ready), .wr_count_out(wr_count));
  initial begin
    sys_clk_in = 1'h0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Returns {flags, result} from the current expected flags.
  function automatic logic [31:0] ref_op(input logic [3:0] op,
    input logic bw, input logic [15:0] s, input logic [15:0] d);
    logic [16:0] t;
    logic [15:0] m, sv, r, f;
    logic [4:0] g;
    logic c;
    int k, b;
    b = bw ? 7 : 15;
    m = bw ? 16'h00ff : 16'hffff;
    s = s & m;
    d = d & m;
    c = sr_exp[0];
    sv = op inside {4'h7, 4'h8, 4'h9} ? ~s & m : s;
    t = 17'h00000;
    case (op)
      4'h5: t = d + sv;
      4'h6, 4'h7: t = d + sv + c;
      4'h8, 4'h9: t = d + sv + 1;
      4'ha: begin
        for (k = 0; k <= b; k += 4) begin
          g = d[k+:4] + s[k+:4] + c;
          c = g > 9;
          t[k+:4] = c ? g[3:0] + 4'h6 : g[3:0];
        end
      end
      4'hb, 4'hf: t = d & s;
      4'hc: t = ~s & d;
      4'hd: t = s | d;
      4'he: t = d ^ s;
      default: t = {1'h0, s};
    endcase
    r = t[15:0] & m;
    f = sr_exp;
    if (!(op inside {4'h4, 4'hc, 4'hd})) begin
      f[2] = r[b];
      f[1] = r == 0;
      f[0] = op inside {4'hb, 4'he, 4'hf} ? r != 0 : op == 4'ha ? c : t[b+1];
      f[8] = op inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9} ?
        sv[b] == d[b] && r[b] != d[b] : op == 4'he && s[b] && d[b];
    end
    return {f, r};
  endfunction
  // One instruction "op src,&a"; the core is stalled at its fetch on entry.
  task automatic run(input logic [3:0] op, input logic bw, input logic cg,
    input logic [15:0] s, input logic [15:0] d, input logic [15:0] a);
    logic [15:0] nx, n0, w;
    logic [31:0] e;
    u_mem.mem[pc_exp[8:1]] = {op, cg ? 4'h3 : 4'h0, 1'h1, bw,
      cg ? 2'h1 : 2'h3, 4'h2};
    u_mem.mem[pc_exp[8:1] + 8'h01] = s;
    nx = pc_exp + (cg ? 16'h0002 : 16'h0004);
    u_mem.mem[nx[8:1]] = a;
    nx = nx + 16'h0002;
    u_mem.mem[a[8:1]] = d;
    s = cg ? 16'h0001 : s;
    e = ref_op(op, bw, s, a[0] ? {8'h00, d[15:8]} : d);
    n0 = wr_count;
    w = {15'h0000, !(op inside {4'h9, 4'hb})};
    stall = 1'h0;
    for (i = 0; i < 100 && !(rd && !busy && addr == nx); i++) begin
      @(negedge sys_clk_in);
    end
    stall = 1'h1;
    check(addr, nx);
    check(sr, e[31:16]);
    check(wr_count - n0, w);
    check(u_mem.mem[a[8:1]], (a[15] || w == 0) ? d : !bw ? e[15:0] :
      a[0] ? {e[7:0], d[7:0]} : {d[15:8], e[7:0]});
    sr_exp = e[31:16];
    pc_exp = nx;
  endtask
  task automatic stop_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    n_fail = 0;
    checks = 0;
    rst_in = 1'h1;
    stall = 1'h1;
    pc_exp = 16'h0000;
    sr_exp = 16'h0000;
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'h0;
    repeat (2) @(negedge sys_clk_in);
    check(sr, 16'h0000);
    run(4'h4, 1'h0, 1'h0, 16'h0045, 16'h1234, 16'h0100);
    run(4'h5, 1'h0, 1'h0, 16'h8000, 16'h8000, 16'h0102);
    run(4'h6, 1'h0, 1'h0, 16'hffff, 16'h0001, 16'h0104);
    run(4'h8, 1'h0, 1'h0, 16'h0001, 16'h0000, 16'h0106);
    run(4'h7, 1'h0, 1'h0, 16'h0003, 16'h0005, 16'h0108);
    run(4'h9, 1'h0, 1'h0, 16'h0007, 16'h0007, 16'h010a);
    run(4'ha, 1'h0, 1'h0, 16'h0199, 16'h0899, 16'h010c);
    run(4'ha, 1'h1, 1'h0, 16'h0055, 16'h4600, 16'h010f);
    run(4'hb, 1'h1, 1'h0, 16'h0080, 16'h0081, 16'h0110);
    run(4'hc, 1'h0, 1'h0, 16'hff00, 16'h1234, 16'h0112);
    run(4'hd, 1'h0, 1'h1, 16'h0000, 16'h1234, 16'h0114);
    run(4'he, 1'h0, 1'h0, 16'h8000, 16'hffff, 16'h0116);
    run(4'hf, 1'h0, 1'h0, 16'h00f0, 16'h0f00, 16'h0118);
    run(4'h5, 1'h1, 1'h1, 16'h0000, 16'h00ff, 16'h011a);
    run(4'h4, 1'h0, 1'h0, 16'h5a5a, 16'h0bad, 16'h8180);
    u_mem.mem[pc_exp[8:1]] = 16'h3c00;
    stall = 1'h0;
    for (i = 0; i < 20 && other_fmt !== 1'h1; i++) begin
      @(negedge sys_clk_in);
    end
    check({14'h0000, fmt}, 16'h0002);
    check({15'h0000, other_fmt}, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire

//--- test/toie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module toie_mem_model (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Bus from the core, and the testbench stall.
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic byte_in,
  input wire logic stall_in,
  // Answers.
  output logic [15:0] rdata_out,
  output logic ready_out,
  output logic [15:0] wr_count_out
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic [7:0] idx;
  assign idx = addr_in[8:1];
  // Outside an answer the data lines flip, so a stale value never matches.
  assign rdata_out = (ready_out && rd_in) ? mem[idx] : ~last;
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_out <= 1'h0;
      last <= 16'h0000;
      wr_count_out <= 16'h0000;
    end else begin
      ready_out <= (rd_in || wr_in) && !ready_out && !stall_in;
      if (ready_out && rd_in) begin
        last <= mem[idx];
      end
      if (ready_out && wr_in) begin
        wr_count_out <= wr_count_out + 16'h0001;
        // The upper half is read-only: writes land and are dropped.
        if (!addr_in[15]) begin
          if (!byte_in) begin
            mem[idx] <= wdata_in;
          end else if (addr_in[0]) begin
            mem[idx][15:8] <= wdata_in[15:8];
          end else begin
            mem[idx][7:0] <= wdata_in[7:0];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire
